// ==== drive_terminal_signal_select.sv ====
`timescale 1ns/1ps
`include "drive_terminal_cfg.svh"

module drive_terminal_signal_select #(
  parameter int DETECT_TICK = `DETECT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Start inputs
  input wire logic forward_start_in_i,
  input wire logic reverse_start_in_i,
  input wire logic stop_hold_in_i,
  input wire logic inching_in_i,
  input wire logic output_shutoff_in_i,
  input wire logic [13:0] start_mode_setting_i,
  // Selection write port
  input wire logic sel_write_i,
  input wire logic [1:0] sel_target_i,
  input wire logic [13:0] sel_code_i,
  // Frequency status
  input wire logic operating_i,
  input wire logic reverse_rotation_i,
  input wire logic [15:0] out_freq_i,
  input wire logic [15:0] set_freq_i,
  input wire logic [15:0] starting_frequency_i,
  input wire logic [15:0] detect_freq_fwd_i,
  input wire logic [15:0] detect_freq_rev_i,
  // Load and thermal status
  input wire logic stall_active_i,
  input wire logic [15:0] regen_duty_i,
  input wire logic [15:0] regen_duty_limit_i,
  input wire logic [15:0] thermal_value_i,
  input wire logic [15:0] thermal_trip_i,
  input wire logic [15:0] heatsink_temp_i,
  input wire logic [15:0] heatsink_trip_i,
  // Current detection
  input wire logic [15:0] out_current_i,
  input wire logic [15:0] high_current_level_i,
  input wire logic [15:0] high_current_time_i,
  input wire logic [15:0] low_current_level_i,
  input wire logic [15:0] low_current_time_i,
  // PID status
  input wire logic pid_active_i,
  input wire logic pid_forward_i,
  input wire logic [15:0] pid_feedback_i,
  input wire logic [15:0] pid_low_limit_i,
  input wire logic [15:0] pid_high_limit_i,
  // Other events
  input wire logic brake_release_req_i,
  input wire logic fan_fault_i,
  input wire logic powerloss_decel_i,
  input wire logic powerloss_release_i,
  input wire logic reattempt_active_i,
  input wire logic fault_event_i,
  input wire logic fault_reset_i,
  input wire logic life_alarm_i,
  input wire logic fault3_i,
  input wire logic current_avg_pulse_i,
  input wire logic maint_timer_i,
  input wire logic remote_out_i,
  input wire logic alarm_i,
  // Rotation command
  output logic forward_run_o,
  output logic reverse_run_o,
  // Terminals
  output logic od1_out_o,
  output logic od1_oe_n_o,
  output logic od2_out_o,
  output logic od2_oe_n_o,
  output logic relay_closed_o,
  // Selection readback
  output logic [13:0] od1_select_o,
  output logic [13:0] od2_select_o,
  output logic [13:0] relay_select_o,
  output logic sel_reject_o
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Value has reached the given percentage of its limit
  function automatic logic pct_reached(input logic [15:0] value,
                                       input logic [15:0] limit,
                                       input logic [6:0] pct);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(value) * 24'(`FULL_PCT);
    rhs = 24'(limit) * 24'(pct);
    pct_reached = (lhs >= rhs);
  endfunction

  // Code is one of the listed selections for a terminal
  function automatic logic code_valid(input logic [13:0] code,
                                      input logic relay);
    logic [13:0] b;
    b = code;
    code_valid = 1'b0;
    if (code == `SEL_NO_FUNCTION) begin
      code_valid = 1'b1;
    end else if (code < `SEL_NEG_LIMIT) begin
      if (code >= `SEL_NEG_OFFSET) begin
        b = code - `SEL_NEG_OFFSET;
      end
      unique case (b)
        14'h0000, 14'h0001, 14'h0003, 14'h0004, 14'h0007, 14'h0008,
        14'h000B, 14'h000C, 14'h000D, 14'h000E, 14'h000F, 14'h0010,
        14'h0014, 14'h0019, 14'h001A, 14'h002E, 14'h002F, 14'h0040,
        14'h005A, 14'h005B, 14'h005F, 14'h0060, 14'h0062,
        14'h0063: code_valid = 1'b1;
        14'h005D: code_valid = !relay;
        default: code_valid = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------

  logic rst_sync1_reg;
  logic rst_n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n <= rst_sync1_reg;
    end
  end

  // --------------------------------------------------------------------
  // Start decode
  // --------------------------------------------------------------------

  drive_terminal_pkg::start_mode_type mode;
  drive_terminal_pkg::start_cmd_type level_cmd;
  drive_terminal_pkg::start_cmd_type cmd_next;
  logic three_wire;
  logic hold_reg;
  logic hold_rev_reg;
  logic start_pressed;

  // Unlisted mode settings fall back to directional decode
  always_comb begin
    if ((start_mode_setting_i >= `START_FR_MIN &&
         start_mode_setting_i <= `START_FR_MAX) ||
        start_mode_setting_i == `START_FR_DECEL_CODE) begin
      mode = drive_terminal_pkg::MODE_START_DIR;
    end else begin
      mode = drive_terminal_pkg::MODE_DIRECTIONAL;
    end
  end

  // Command from the input levels alone
  always_comb begin
    level_cmd = drive_terminal_pkg::CMD_STOP;
    if (mode == drive_terminal_pkg::MODE_DIRECTIONAL) begin
      if (forward_start_in_i && !reverse_start_in_i) begin
        level_cmd = drive_terminal_pkg::CMD_FORWARD;
      end else if (reverse_start_in_i && !forward_start_in_i) begin
        level_cmd = drive_terminal_pkg::CMD_REVERSE;
      end
    end else if (forward_start_in_i) begin
      level_cmd = reverse_start_in_i ? drive_terminal_pkg::CMD_REVERSE :
                                       drive_terminal_pkg::CMD_FORWARD;
    end
  end

  // Jog disables the stop input, so self-holding is off meanwhile
  assign three_wire = stop_hold_in_i && !inching_in_i;
  assign start_pressed = (mode == drive_terminal_pkg::MODE_DIRECTIONAL) ?
                         (forward_start_in_i || reverse_start_in_i) :
                         forward_start_in_i;

  // Self-holding latch; shutoff is deliberately not a clear term
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
      hold_rev_reg <= 1'b0;
    end else if (!inching_in_i) begin
      if (!stop_hold_in_i) begin
        hold_reg <= 1'b0;
      end else if (start_pressed && level_cmd !=
                   drive_terminal_pkg::CMD_STOP) begin
        hold_reg <= 1'b1;
        hold_rev_reg <= (level_cmd == drive_terminal_pkg::CMD_REVERSE);
      end
    end
  end

  // Held direction wins while the latch is set outside jog; shutoff wins over both
  always_comb begin
    cmd_next = level_cmd;
    if (three_wire && hold_reg) begin
      cmd_next = hold_rev_reg ? drive_terminal_pkg::CMD_REVERSE :
                                drive_terminal_pkg::CMD_FORWARD;
    end
    if (output_shutoff_in_i) begin
      cmd_next = drive_terminal_pkg::CMD_STOP;
    end
  end

  // Registered rotation command
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      forward_run_o <= 1'b0;
      reverse_run_o <= 1'b0;
    end else begin
      forward_run_o <= (cmd_next == drive_terminal_pkg::CMD_FORWARD);
      reverse_run_o <= (cmd_next == drive_terminal_pkg::CMD_REVERSE);
    end
  end

  // --------------------------------------------------------------------
  // Terminal selections
  // --------------------------------------------------------------------

  logic [13:0] od1_sel_reg;
  logic [13:0] od2_sel_reg;
  logic [13:0] relay_sel_reg;
  logic write_ok;

  // Target 3 is not a terminal and is refused like a bad code
  always_comb begin
    unique case (sel_target_i)
      `SEL_TGT_OD1: write_ok = code_valid(sel_code_i, 1'b0);
      `SEL_TGT_OD2: write_ok = code_valid(sel_code_i, 1'b0);
      `SEL_TGT_RELAY: write_ok = code_valid(sel_code_i, 1'b1);
      default: write_ok = 1'b0;
    endcase
  end

  // No cross-check between terminals: duplicates are legal
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      od1_sel_reg <= `SEL_OD1_RESET;
      od2_sel_reg <= `SEL_OD2_RESET;
      relay_sel_reg <= `SEL_RELAY_RESET;
      sel_reject_o <= 1'b0;
    end else begin
      sel_reject_o <= sel_write_i && !write_ok;
      if (sel_write_i && write_ok) begin
        if (sel_target_i == `SEL_TGT_OD1) begin
          od1_sel_reg <= sel_code_i;
        end
        if (sel_target_i == `SEL_TGT_OD2) begin
          od2_sel_reg <= sel_code_i;
        end
        if (sel_target_i == `SEL_TGT_RELAY) begin
          relay_sel_reg <= sel_code_i;
        end
      end
    end
  end

  assign od1_select_o = od1_sel_reg;
  assign od2_select_o = od2_sel_reg;
  assign relay_select_o = relay_sel_reg;

  // --------------------------------------------------------------------
  // Held flags and detection timers
  // --------------------------------------------------------------------

  logic ready_reg;
  logic powerloss_reg;
  logic fault_reg;
  logic [17:0] tick_cnt_reg;
  logic tick;
  logic [15:0] high_cnt_reg;
  logic [15:0] low_cnt_reg;
  logic high_flag;
  logic low_flag;

  // Sticky flags; a new event beats a simultaneous release
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      powerloss_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
      if (powerloss_decel_i) begin
        powerloss_reg <= 1'b1;
      end else if (powerloss_release_i) begin
        powerloss_reg <= 1'b0;
      end
      if (fault_event_i) begin
        fault_reg <= 1'b1;
      end else if (fault_reset_i) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // Time base for the current detection settings
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 18'h00000;
    end else if (tick) begin
      tick_cnt_reg <= 18'h00000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 18'h00001;
    end
  end

  assign tick = (tick_cnt_reg == 18'(DETECT_TICK - 1));

  // Counters saturate so a long level cannot wrap back under the setting
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_reg <= 16'h0000;
    end else if (out_current_i <= high_current_level_i) begin
      high_cnt_reg <= 16'h0000;
    end else if (tick && high_cnt_reg != 16'hFFFF) begin
      high_cnt_reg <= high_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 16'h0000;
    end else if (out_current_i >= low_current_level_i) begin
      low_cnt_reg <= 16'h0000;
    end else if (tick && low_cnt_reg != 16'hFFFF) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end

  assign high_flag = (high_cnt_reg > high_current_time_i);
  assign low_flag = (low_cnt_reg > low_current_time_i);

  // --------------------------------------------------------------------
  // Condition vector
  // --------------------------------------------------------------------

  logic [`COND_COUNT-1:0] cond_vec;
  logic [15:0] detect_level;

  assign detect_level = reverse_rotation_i ? detect_freq_rev_i :
                                             detect_freq_fwd_i;

  // One bit per positive code; unused codes stay false
  always_comb begin
    cond_vec = '0;
    cond_vec[`C_RUNNING] = operating_i &&
                           out_freq_i >= starting_frequency_i;
    cond_vec[`C_SPEED_ARRIVED] = operating_i &&
                                 out_freq_i == set_freq_i;
    cond_vec[`C_OVERLOAD] = stall_active_i;
    cond_vec[`C_FREQ_DETECT] = out_freq_i >= detect_level;
    cond_vec[`C_REGEN_PREWARN] = pct_reached(regen_duty_i,
      regen_duty_limit_i, `PREWARN_PCT);
    cond_vec[`C_THERMAL_PREWARN] = pct_reached(thermal_value_i,
      thermal_trip_i, `PREWARN_PCT);
    cond_vec[`C_READY] = ready_reg && !fault_reg &&
                         !output_shutoff_in_i;
    cond_vec[`C_OVERCURRENT] = high_flag;
    cond_vec[`C_LOW_CURRENT] = low_flag;
    cond_vec[`C_FEEDBACK_LOW] = pid_active_i &&
                                pid_feedback_i < pid_low_limit_i;
    cond_vec[`C_FEEDBACK_HIGH] = pid_active_i &&
                                 pid_feedback_i > pid_high_limit_i;
    cond_vec[`C_PID_FORWARD] = pid_active_i && pid_forward_i;
    cond_vec[`C_BRAKE_RELEASE] = brake_release_req_i;
    cond_vec[`C_FAN_FAULT] = fan_fault_i;
    cond_vec[`C_HEATSINK_WARN] = pct_reached(heatsink_temp_i,
      heatsink_trip_i, `PREWARN_PCT);
    cond_vec[`C_POWERLOSS] = powerloss_reg;
    cond_vec[`C_PID_ACTIVE] = pid_active_i;
    cond_vec[`C_REATTEMPT] = reattempt_active_i;
    cond_vec[`C_LIFE_ALARM] = life_alarm_i;
    cond_vec[`C_FAULT3] = fault3_i;
    cond_vec[`C_CURRENT_AVG] = current_avg_pulse_i;
    cond_vec[`C_MAINT_TIMER] = maint_timer_i;
    cond_vec[`C_REMOTE] = remote_out_i;
    cond_vec[`C_ALARM] = alarm_i;
    cond_vec[`C_FAULT_TRIP] = fault_reg;
  end

  // --------------------------------------------------------------------
  // Terminal drivers
  // --------------------------------------------------------------------

  logic od1_conduct;
  logic od2_conduct;
  logic relay_conduct;

  terminal_cond_mux od1_mux (
    .code_i(od1_sel_reg),
    .cond_vec_i(cond_vec),
    .conduct_o(od1_conduct)
  );

  terminal_cond_mux od2_mux (
    .code_i(od2_sel_reg),
    .cond_vec_i(cond_vec),
    .conduct_o(od2_conduct)
  );

  terminal_cond_mux relay_mux (
    .code_i(relay_sel_reg),
    .cond_vec_i(cond_vec),
    .conduct_o(relay_conduct)
  );

  // Open collector pulls low when conducting, enable is active low
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      od1_out_o <= 1'b0;
      od1_oe_n_o <= 1'b1;
      od2_out_o <= 1'b0;
      od2_oe_n_o <= 1'b1;
      relay_closed_o <= 1'b0;
    end else begin
      od1_out_o <= 1'b0;
      od1_oe_n_o <= !od1_conduct;
      od2_out_o <= 1'b0;
      od2_oe_n_o <= !od2_conduct;
      relay_closed_o <= relay_conduct;
    end
  end

endmodule

// ==== drive_terminal_cfg.svh ====
`ifndef DRIVE_TERMINAL_CFG_SVH
`define DRIVE_TERMINAL_CFG_SVH

// ----------------------------------------------------------------------
// Start mode setting values
// ----------------------------------------------------------------------
`define START_TWO_WIRE_MAX 14'h0064
`define START_DECEL_CODE 14'h270F
`define START_FR_MIN 14'h03E8
`define START_FR_MAX 14'h044C
`define START_FR_DECEL_CODE 14'h22B8

// ----------------------------------------------------------------------
// Terminal selection codes
// ----------------------------------------------------------------------
`define SEL_CODE_W 14
`define SEL_NO_FUNCTION 14'h270F
`define SEL_NEG_OFFSET 14'h0064
`define SEL_NEG_LIMIT 14'h00C8
`define SEL_OD1_RESET 14'h0000
`define SEL_OD2_RESET 14'h0004
`define SEL_RELAY_RESET 14'h0063
`define SEL_TGT_OD1 2'h0
`define SEL_TGT_OD2 2'h1
`define SEL_TGT_RELAY 2'h2

// ----------------------------------------------------------------------
// Condition codes (positive form)
// ----------------------------------------------------------------------
`define C_RUNNING 0
`define C_SPEED_ARRIVED 1
`define C_OVERLOAD 3
`define C_FREQ_DETECT 4
`define C_REGEN_PREWARN 7
`define C_THERMAL_PREWARN 8
`define C_READY 11
`define C_OVERCURRENT 12
`define C_LOW_CURRENT 13
`define C_FEEDBACK_LOW 14
`define C_FEEDBACK_HIGH 15
`define C_PID_FORWARD 16
`define C_BRAKE_RELEASE 20
`define C_FAN_FAULT 25
`define C_HEATSINK_WARN 26
`define C_POWERLOSS 46
`define C_PID_ACTIVE 47
`define C_REATTEMPT 64
`define C_LIFE_ALARM 90
`define C_FAULT3 91
`define C_CURRENT_AVG 93
`define C_MAINT_TIMER 95
`define C_REMOTE 96
`define C_ALARM 98
`define C_FAULT_TRIP 99
`define COND_COUNT 100

// ----------------------------------------------------------------------
// Levels and timing
// ----------------------------------------------------------------------
`define PREWARN_PCT 7'h55
`define FULL_PCT 7'h64
`define DETECT_TIME_UNIT_US 1000
`define CLK_MHZ 250
`define DETECT_TICK_CYCLES (`DETECT_TIME_UNIT_US * `CLK_MHZ)

`endif

// ==== drive_terminal_pkg.sv ====
package drive_terminal_pkg;

  // Decoded rotation command
  typedef enum logic [1:0] {
    CMD_STOP,
    CMD_FORWARD,
    CMD_REVERSE
  } start_cmd_type;

  // Meaning of the two start inputs
  typedef enum logic {
    MODE_DIRECTIONAL,
    MODE_START_DIR
  } start_mode_type;

endpackage

// ==== terminal_cond_mux.sv ====
`timescale 1ns/1ps
`include "drive_terminal_cfg.svh"

// Picks one status condition and applies the polarity of the code
module terminal_cond_mux (
  // Selection
  input wire logic [`SEL_CODE_W-1:0] code_i,
  // Conditions indexed by positive code
  input wire logic [`COND_COUNT-1:0] cond_vec_i,
  // Terminal state
  output logic conduct_o
);

  logic [`SEL_CODE_W-1:0] base;
  logic invert;
  logic cond;

  // Codes in the upper hundred select the same condition inverted
  always_comb begin
    invert = 1'b0;
    base = code_i;
    cond = 1'b0;
    if (code_i >= `SEL_NEG_OFFSET && code_i < `SEL_NEG_LIMIT) begin
      invert = 1'b1;
      base = code_i - `SEL_NEG_OFFSET;
    end
    if (base < `SEL_NEG_OFFSET) begin
      cond = cond_vec_i[base[6:0]];
    end
    // True condition conducts for positive codes only
    conduct_o = cond ^ invert;
  end

endmodule

// ==== drive_terminal_far_side.sv ====
`timescale 1ns/1ps
// Controller side of the terminals: open collectors with pull-ups
module drive_terminal_far_side (
  // Terminal drive from the block
  input wire logic od1_out_o,
  input wire logic od1_oe_n_o,
  input wire logic od2_out_o,
  input wire logic od2_oe_n_o,
  // Levels seen by the controller
  output logic od1_pin_o,
  output logic od2_pin_o
);
  // A released collector floats up to the rail, never holds its last level
  assign od1_pin_o = od1_oe_n_o ? 1'b1 : od1_out_o;
  assign od2_pin_o = od2_oe_n_o ? 1'b1 : od2_out_o;
endmodule

// ==== drive_terminal_signal_select_props.sv ====
`timescale 1ns/1ps
module drive_terminal_signal_select_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Start inputs
  input wire logic forward_start_in_i, reverse_start_in_i, stop_hold_in_i,
  input wire logic inching_in_i, output_shutoff_in_i,
  input wire logic [13:0] start_mode_setting_i,
  // Selection port
  input wire logic sel_write_i,
  input wire logic [1:0] sel_target_i,
  input wire logic [13:0] sel_code_i,
  // Status
  input wire logic operating_i, fault_event_i,
  input wire logic [15:0] out_freq_i, starting_frequency_i,
  // Outputs
  input wire logic forward_run_o, reverse_run_o, od1_oe_n_o,
  input wire logic relay_closed_o, sel_reject_o,
  input wire logic [13:0] od1_select_o, od2_select_o, relay_select_o
);
  logic [1:0] up_reg;
  // Internal reset trails the pin by two edges, so judge only after that
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (up_reg != 2'h3);
  property p_sel_reset;
    disable iff (!reset_n_i) $rose(reset_n_i) |-> od1_select_o == 14'h0000
      && od2_select_o == 14'h0004 && relay_select_o == 14'h0063;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("selections not at reset codes");
  property p_relay_refuse;
    sel_write_i && sel_target_i == 2'h2 && (sel_code_i == 14'h005D
      || sel_code_i == 14'h00C1) |=> sel_reject_o && $stable(relay_select_o);
  endproperty
  a_relay_refuse: assert property (p_relay_refuse)
    else $error("relay took a pulse code");
  property p_od_accept;
    sel_write_i && sel_target_i == 2'h1 && sel_code_i == 14'h00C1
      |=> !sel_reject_o && od2_select_o == 14'h00C1;
  endproperty
  a_od_accept: assert property (p_od_accept)
    else $error("open collector refused a pulse code");
  property p_bad_code;
    sel_write_i && sel_target_i == 2'h0 && sel_code_i == 14'h0002
      |=> sel_reject_o && $stable(od1_select_o);
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("unlisted code accepted");
  property p_running;
    od1_select_o == 14'h0000 && operating_i && !sel_write_i
      && out_freq_i >= starting_frequency_i && !output_shutoff_in_i
      |=> !od1_oe_n_o;
  endproperty
  a_running: assert property (p_running)
    else $error("running not shown on terminal");
  property p_fault_hold;
    relay_select_o == 14'h0063 && fault_event_i && !sel_write_i
      |-> ##2 relay_closed_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault not on relay");
  sequence s_plain;
    !stop_hold_in_i && !output_shutoff_in_i && !inching_in_i;
  endsequence
  property p_fwd_only;
    start_mode_setting_i == 14'h270F && forward_start_in_i
      && !reverse_start_in_i ##0 s_plain |=> forward_run_o && !reverse_run_o;
  endproperty
  a_fwd_only: assert property (p_fwd_only)
    else $error("forward decode wrong");
  property p_both_stop;
    start_mode_setting_i == 14'h270F && forward_start_in_i
      && reverse_start_in_i && !stop_hold_in_i
      |=> !forward_run_o && !reverse_run_o;
  endproperty
  a_both_stop: assert property (p_both_stop)
    else $error("both starts did not stop");
  property p_dir_mode;
    start_mode_setting_i == 14'h03E8 && forward_start_in_i
      && reverse_start_in_i ##0 s_plain |=> reverse_run_o && !forward_run_o;
  endproperty
  a_dir_mode: assert property (p_dir_mode)
    else $error("direction mode decode wrong");
  property p_shutoff;
    output_shutoff_in_i |=> !forward_run_o && !reverse_run_o;
  endproperty
  a_shutoff: assert property (p_shutoff)
    else $error("run command during shutoff");
  c_refuse: cover property (sel_reject_o);
  c_forward: cover property (forward_run_o);
  c_relay: cover property (relay_closed_o);
endmodule

bind drive_terminal_signal_select drive_terminal_signal_select_props
  u_drive_terminal_signal_select_props (.*);

// ==== drive_terminal_signal_select_tb_top.sv ====
`timescale 1ns/1ps
module drive_terminal_signal_select_tb_top;
  logic mclk_i='0, reset_n_i='0, forward_start_in_i='0;
  logic reverse_start_in_i='0, stop_hold_in_i='0, inching_in_i='0;
  logic output_shutoff_in_i='0, sel_write_i='0, operating_i='0;
  logic reverse_rotation_i='0, stall_active_i='0, pid_active_i='0;
  logic pid_forward_i='0, brake_release_req_i='0, fan_fault_i='0;
  logic powerloss_decel_i='0, powerloss_release_i='0, alarm_i='0;
  logic reattempt_active_i='0, fault_event_i='0, fault_reset_i='0;
  logic life_alarm_i='0, fault3_i='0, current_avg_pulse_i='0;
  logic maint_timer_i='0, remote_out_i='0;
  logic [1:0] sel_target_i='0;
  logic [13:0] start_mode_setting_i=14'h270F, sel_code_i='0;
  logic [15:0] out_freq_i=16'h0010, set_freq_i='0, detect_freq_rev_i='0;
  logic [15:0] starting_frequency_i=16'h0008, detect_freq_fwd_i='0;
  logic [15:0] regen_duty_i='0, regen_duty_limit_i='0, thermal_value_i='0;
  logic [15:0] thermal_trip_i='0, heatsink_temp_i='0, heatsink_trip_i='0;
  logic [15:0] out_current_i='0, high_current_level_i='0;
  logic [15:0] high_current_time_i='0, low_current_level_i='0;
  logic [15:0] low_current_time_i='0, pid_feedback_i='0;
  logic [15:0] pid_low_limit_i='0, pid_high_limit_i='0;
  logic forward_run_o, reverse_run_o, od1_out_o, od1_oe_n_o, od2_out_o;
  logic od2_oe_n_o, relay_closed_o, sel_reject_o, od1_pin_o, od2_pin_o;
  logic [13:0] od1_select_o, od2_select_o, relay_select_o;
  int fail_count = 0;
  int samples_checked = 0;
  // Running, stall, brake, fan, PID active, retry
  localparam logic [13:0] CODES [6] = '{14'h0000, 14'h0003, 14'h0014,
    14'h0019, 14'h002F, 14'h0040};
  drive_terminal_signal_select #(.DETECT_TICK(4))
    u_drive_terminal_signal_select (.*);
  drive_terminal_far_side u_drive_terminal_far_side (.*);
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // One write strobe, reject pulse looked at in its only cycle
  task wr(input logic [1:0] t, input logic [13:0] c, input logic rej);
    sel_write_i = 1'b1;
    sel_target_i = t;
    sel_code_i = c;
    tick(1);
    sel_write_i = 1'b0;
    chk(sel_reject_o, rej);
    tick(1);
  endtask
  task run(input logic f, input logic r, input logic ef, input logic er);
    forward_start_in_i = f;
    reverse_start_in_i = r;
    tick(2);
    chk(forward_run_o, ef);
    chk(reverse_run_o, er);
  endtask
  task end_sim;
    $display("checks=%0d failures=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short; the whole sequence needs well under 1 us
  initial begin
    #20000;
    fail_count++;
    end_sim;
  end
  initial begin
    tick(5);
    reset_n_i = 1'b1;
    tick(3);
    chk(od1_select_o, 14'h0000);
    chk(od2_select_o, 14'h0004);
    chk(relay_select_o, 14'h0063);
    wr(2'h2, 14'h005D, 1'b1);
    wr(2'h2, 14'h00C1, 1'b1);
    chk(relay_select_o, 14'h0063);
    wr(2'h0, 14'h005D, 1'b0);
    wr(2'h1, 14'h00C1, 1'b0);
    chk(od2_select_o, 14'h00C1);
    wr(2'h0, 14'h0002, 1'b1);
    wr(2'h3, 14'h0000, 1'b1);
    chk(od1_select_o, 14'h005D);
    // Fault code on all three terminals, one of them inverted
    wr(2'h0, 14'h0063, 1'b0);
    wr(2'h1, 14'h00C7, 1'b0);
    wr(2'h2, 14'h0063, 1'b0);
    fault_event_i = 1'b1;
    tick(1);
    fault_event_i = 1'b0;
    tick(3);
    chk(od1_pin_o, 1'b0);
    chk(od2_pin_o, 1'b1);
    chk(relay_closed_o, 1'b1);
    fault_reset_i = 1'b1;
    tick(1);
    fault_reset_i = 1'b0;
    tick(3);
    chk(relay_closed_o, 1'b0);
    chk(od2_pin_o, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(2'h0, CODES[i], 1'b0);
      wr(2'h1, CODES[i] + 14'h0064, 1'b0);
      {operating_i, stall_active_i, brake_release_req_i, fan_fault_i,
        pid_active_i, reattempt_active_i} = 6'h20 >> i;
      tick(2);
      chk(od1_oe_n_o, 1'b0);
      chk(od2_oe_n_o, 1'b1);
      {operating_i, stall_active_i, brake_release_req_i, fan_fault_i,
        pid_active_i, reattempt_active_i} = 6'h00;
      tick(2);
      chk(od1_oe_n_o, 1'b1);
    end
    wr(2'h0, 14'h000B, 1'b0);
    chk(od1_oe_n_o, 1'b0);
    // Current flag waits for the next tick pulse above the level, never at once
    wr(2'h0, 14'h000C, 1'b0);
    out_current_i = 16'h0010;
    tick(1);
    chk(od1_oe_n_o, 1'b1);
    tick(6);
    chk(od1_oe_n_o, 1'b0);
    out_current_i = 16'h0000;
    // Detect level follows the direction of rotation
    wr(2'h0, 14'h0004, 1'b0);
    detect_freq_fwd_i = 16'h0011;
    tick(2);
    chk(od1_oe_n_o, 1'b1);
    reverse_rotation_i = 1'b1;
    tick(2);
    chk(od1_oe_n_o, 1'b0);
    // Power-loss flag stays after its one-cycle event
    wr(2'h0, 14'h002E, 1'b0);
    powerloss_decel_i = 1'b1;
    tick(1);
    powerloss_decel_i = 1'b0;
    tick(3);
    chk(od1_oe_n_o, 1'b0);
    // Two-wire decode, then start plus direction
    run(1'b1, 1'b0, 1'b1, 1'b0);
    run(1'b0, 1'b1, 1'b0, 1'b1);
    run(1'b1, 1'b1, 1'b0, 1'b0);
    start_mode_setting_i = 14'h03E8;
    run(1'b1, 1'b1, 1'b0, 1'b1);
    run(1'b0, 1'b1, 1'b0, 1'b0);
    start_mode_setting_i = 14'h22B8;
    run(1'b1, 1'b1, 1'b0, 1'b1);
    start_mode_setting_i = 14'h0032;
    run(1'b1, 1'b1, 1'b0, 1'b0);
    // Held start survives shutoff and a jog with the stop input dropped
    start_mode_setting_i = 14'h270F;
    stop_hold_in_i = 1'b1;
    run(1'b1, 1'b0, 1'b1, 1'b0);
    run(1'b0, 1'b0, 1'b1, 1'b0);
    output_shutoff_in_i = 1'b1;
    tick(2);
    chk(forward_run_o, 1'b0);
    output_shutoff_in_i = 1'b0;
    tick(2);
    chk(forward_run_o, 1'b1);
    inching_in_i = 1'b1;
    stop_hold_in_i = 1'b0;
    tick(3);
    stop_hold_in_i = 1'b1;
    inching_in_i = 1'b0;
    tick(2);
    chk(forward_run_o, 1'b1);
    stop_hold_in_i = 1'b0;
    tick(2);
    chk(forward_run_o, 1'b0);
    // Reset in mid-run brings back the default selections
    reset_n_i = 1'b0;
    tick(2);
    reset_n_i = 1'b1;
    tick(3);
    chk(od1_select_o, 14'h0000);
    chk(od2_select_o, 14'h0004);
    end_sim;
  end
endmodule
